//--- common/rce_pkg.sv
package rce_pkg;
  // Register width and the divisor forms.
  localparam int CRC_W = 16;
  localparam logic [16:0] POLY_FULL = 17'h1_8005;
  localparam logic [15:0] POLY_REFL = 16'hA001;
  localparam logic [15:0] CRC_PRESET = 16'hFFFF;
  localparam logic [15:0] CRC_GOOD = 16'h0000;
  // Shift steps per byte and check bytes per frame.
  localparam logic [3:0] SHIFTS_PER_BYTE = 4'h8;
  localparam logic [3:0] SHIFT_LAST = 4'h7;
  localparam int CHECK_BYTES = 2;
  // Default width of the byte counter and length input.
  localparam int LEN_W_DEF = 9;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ABSORB = 3'b001,
    ST_SHIFT = 3'b010,
    ST_APPEND = 3'b011,
    ST_DONE = 3'b100
  } rce_state_e;
endpackage

//--- rtl/rce_crc16_engine.sv
`timescale 1ns/1ps
// Summary of operation
// R1: Transmitter appends two check bytes after data; a zero-length transmit frame goes idle and appends none.
// R2: Receiver recomputes check value with same algorithm.
// R3: Divisor polynomial has powers 16, 15, 2, 0.
// R4: Right shift, feedback constant A001, x16 dropped.
// R5: Preset register to all ones per frame.
// R6: XOR each byte into the low half.
// R7: Shift right once, low bit becomes flag.
// R8: Flag one XORs constant, zero leaves register.
// R9: Exactly eight shift steps per absorbed byte.
// R10: Serial form feeds bits 15, 13 and 0.
// R11: Count bytes, stop past the data length.
// R12: Transmitter sends final register as check bytes.
// R13: Receiver absorbs check bytes, good when zero.
// R14: Low register half goes out first.
// R15: Register after data equals received check value.
// R16: Check covers address, function and information bytes.
// R17: Sticky check error, cleared by next preset.
// R18: Byte handshake, ready low while shifting.
// R19: Synchronous clear presets register, clears counters, flag.
module rce_crc16_engine #(
  parameter int LEN_W = rce_pkg::LEN_W_DEF
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic syncClr,
  input wire logic frameStart,
  input wire logic txMode,
  input wire logic [LEN_W-1:0] dataLen,
  input wire logic inValid,
  output logic inReady,
  input wire logic [7:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [7:0] outData,
  output logic [rce_pkg::CRC_W-1:0] crcValue,
  output logic frameDone,
  output logic frameGood,
  output logic checkMatch,
  output logic checkErr
);
  import rce_pkg::*;

  rce_state_e state_r, state_nxt;
  logic [CRC_W-1:0] crc_r, crc_nxt;
  logic [CRC_W-1:0] snap_r, snap_nxt;
  logic [CRC_W-1:0] rxChk_r, rxChk_nxt;
  logic [CRC_W-1:0] byteRef_r, byteRef_nxt;
  logic [3:0] shiftCnt_r, shiftCnt_nxt;
  logic [LEN_W-1:0] byteCnt_r, byteCnt_nxt;
  logic [LEN_W-1:0] len_r, len_nxt;
  logic tx_r, tx_nxt;
  logic sel_r, sel_nxt;
  logic [7:0] outData_r, outData_nxt;
  logic done_r, done_nxt;
  logic good_r, good_nxt;
  logic match_r, match_nxt;
  logic err_r, err_nxt;
  logic [CRC_W-1:0] stepVal;
  logic [LEN_W-1:0] cntInc;
  logic [LEN_W-1:0] limit;
  logic accept;

  // One bit-serial step: the low bit meets the data bit, and the result is
  // fed into bits 0 and 13 beside the shifted neighbours and into bit 15.
  function automatic logic [CRC_W-1:0] crcStep(input logic [CRC_W-1:0] c,
                                                input logic d);
    logic fb;
    logic [CRC_W-1:0] r;
    fb = c[0] ^ d; // R7 R10
    r = c >> 1; // R7
    if (fb) begin
      r = r ^ POLY_REFL; // R3 R4 R8 R10
    end
    return r;
  endfunction

  // Whole-byte reference: the byte lands in the low half, then eight steps.
  function automatic logic [CRC_W-1:0] crcByte(input logic [CRC_W-1:0] c,
                                                input logic [7:0] b);
    logic [CRC_W-1:0] r;
    r = c ^ {8'h00, b}; // R6
    for (int i = 0; i < 8; i++) begin
      r = crcStep(r, 1'b0); // R9
    end
    return r;
  endfunction

  // Handshake outputs are decoded from the state; ready drops while shifting.
  assign inReady = (state_r == ST_ABSORB); // R18
  assign outValid = (state_r == ST_APPEND); // R1
  assign accept = inValid && inReady;
  assign outData = outData_r;
  assign crcValue = crc_r;
  assign frameDone = done_r;
  assign frameGood = good_r;
  assign checkMatch = match_r;
  assign checkErr = err_r;
  assign stepVal = crcStep(crc_r, 1'b0);
  assign cntInc = byteCnt_r + 1'b1;
  // The receiver also absorbs the two trailing check bytes.
  assign limit = tx_r ? len_r : LEN_W'(len_r + LEN_W'(CHECK_BYTES)); // R13

  // Next-state logic of the whole engine. The frame length must be known at
  // preset, since nothing downstream can stretch a frame once it is counted.
  always_comb begin
    state_nxt = state_r;
    crc_nxt = crc_r;
    snap_nxt = snap_r;
    rxChk_nxt = rxChk_r;
    byteRef_nxt = byteRef_r;
    shiftCnt_nxt = shiftCnt_r;
    byteCnt_nxt = byteCnt_r;
    len_nxt = len_r;
    tx_nxt = tx_r;
    sel_nxt = sel_r;
    outData_nxt = outData_r;
    done_nxt = 1'b0;
    good_nxt = good_r;
    match_nxt = match_r;
    err_nxt = err_r;
    case (state_r)
      ST_IDLE, ST_DONE: begin
      end
      ST_ABSORB: begin
        if (accept) begin
          crc_nxt = crc_r ^ {8'h00, inData}; // R6 R16
          byteRef_nxt = crcByte(crc_r, inData);
          shiftCnt_nxt = 4'h0;
          state_nxt = ST_SHIFT;
          // Keep the received check bytes for the alternative comparison.
          if (!tx_r && byteCnt_r == len_r) begin
            rxChk_nxt[7:0] = inData; // R14
          end
          if (!tx_r && byteCnt_r == LEN_W'(len_r + 1'b1)) begin
            rxChk_nxt[15:8] = inData; // R14
          end
        end
      end
      ST_SHIFT: begin
        crc_nxt = stepVal; // R7 R8
        shiftCnt_nxt = shiftCnt_r + 4'h1;
        if (shiftCnt_r == SHIFT_LAST) begin // R9
          byteCnt_nxt = cntInc; // R11
          if (!tx_r && cntInc == len_r) begin
            snap_nxt = stepVal; // R15
          end
          if (cntInc == limit) begin // R11
            if (tx_r) begin
              outData_nxt = stepVal[7:0]; // R12 R14
              sel_nxt = 1'b0;
              state_nxt = ST_APPEND;
            end else begin
              done_nxt = 1'b1;
              good_nxt = (stepVal == CRC_GOOD); // R2 R13
              match_nxt = (snap_r == rxChk_r); // R15
              state_nxt = ST_DONE;
            end
          end else begin
            state_nxt = ST_ABSORB;
          end
        end
      end
      ST_APPEND: begin
        if (outReady) begin
          if (!sel_r) begin
            outData_nxt = crc_r[15:8]; // R14
            sel_nxt = 1'b1;
          end else begin
            done_nxt = 1'b1;
            good_nxt = 1'b1;
            state_nxt = ST_DONE; // R12
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    // A new frame presets the register and drops the previous verdict.
    if (frameStart) begin
      crc_nxt = CRC_PRESET; // R5
      // With no data bytes the register after data is the preset itself.
      snap_nxt = CRC_PRESET; // R15
      // A frame cut short by a new preset gives no verdict pulse.
      done_nxt = 1'b0;
      byteCnt_nxt = '0;
      shiftCnt_nxt = 4'h0;
      len_nxt = dataLen;
      tx_nxt = txMode;
      good_nxt = 1'b0;
      match_nxt = 1'b0;
      err_nxt = 1'b0; // R17
      state_nxt = (dataLen == '0 && txMode) ? ST_IDLE : ST_ABSORB;
    end
    // A bad frame ending in the preset cycle still raises the flag.
    if (state_r == ST_SHIFT && shiftCnt_r == SHIFT_LAST && !tx_r &&
        cntInc == limit && stepVal != CRC_GOOD) begin
      err_nxt = 1'b1; // R17
    end
    if (syncClr) begin
      state_nxt = ST_IDLE;
      crc_nxt = CRC_PRESET; // R19
      shiftCnt_nxt = 4'h0;
      byteCnt_nxt = '0;
      err_nxt = 1'b0;
      done_nxt = 1'b0;
    end
  end

  // All state freezes while the clock enable is low.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      crc_r <= CRC_PRESET;
      snap_r <= '0;
      rxChk_r <= '0;
      byteRef_r <= '0;
      shiftCnt_r <= 4'h0;
      byteCnt_r <= '0;
      len_r <= '0;
      tx_r <= 1'b0;
      sel_r <= 1'b0;
      outData_r <= 8'h00;
      done_r <= 1'b0;
      good_r <= 1'b0;
      match_r <= 1'b0;
      err_r <= 1'b0;
    end else if (clkEn) begin
      state_r <= state_nxt;
      crc_r <= crc_nxt;
      snap_r <= snap_nxt;
      rxChk_r <= rxChk_nxt;
      byteRef_r <= byteRef_nxt;
      shiftCnt_r <= shiftCnt_nxt;
      byteCnt_r <= byteCnt_nxt;
      len_r <= len_nxt;
      tx_r <= tx_nxt;
      sel_r <= sel_nxt;
      outData_r <= outData_nxt;
      done_r <= done_nxt;
      good_r <= good_nxt;
      match_r <= match_nxt;
      err_r <= err_nxt;
    end
  end

  // Checks on the engine; the clock enable is held in the antecedents of the preset, ready, byte, span and high-byte checks.
  a_preset_ones: assert property (@(posedge clk_sys) disable iff (!rst_n) // R5
    clkEn && frameStart |=> crc_r == CRC_PRESET)
    else $error("register not preset to all ones");

  a_ready_busy: assert property (@(posedge clk_sys) disable iff (!rst_n) // R18
    clkEn && accept && !frameStart && !syncClr |=> !inReady)
    else $error("ready high right after a byte was taken");

  a_byte_result: assert property (@(posedge clk_sys) disable iff (!rst_n) // R9
    clkEn && !syncClr && !frameStart && state_r == ST_SHIFT &&
    shiftCnt_r == SHIFT_LAST |=> crc_r == byteRef_r)
    else $error("byte result differs from eight steps");

  a_shift_span: assert property (@(posedge clk_sys) disable iff (!rst_n) // R9
    (clkEn && accept && !frameStart && !syncClr) ##1
    (clkEn && !frameStart && !syncClr)[*8] |=> state_r != ST_SHIFT)
    else $error("shift phase not eight cycles");

  a_count_bound: assert property (@(posedge clk_sys) disable iff (!rst_n) // R11
    state_r == ST_ABSORB |-> byteCnt_r < limit)
    else $error("absorbing past the frame length");

  a_low_first: assert property (@(posedge clk_sys) disable iff (!rst_n) // R14
    outValid && !sel_r |-> outData == crc_r[7:0])
    else $error("first check byte is not the low half");

  a_high_next: assert property (@(posedge clk_sys) disable iff (!rst_n) // R14
    clkEn && !syncClr && !frameStart && outValid && outReady && !sel_r
    |=> outValid && outData == crc_r[15:8])
    else $error("second check byte is not the high half");

  a_rx_verdict: assert property (@(posedge clk_sys) disable iff (!rst_n) // R13
    frameDone && !tx_r |-> frameGood == (crc_r == CRC_GOOD) &&
    checkErr == !frameGood)
    else $error("receive verdict does not match register");

  a_err_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n) // R17
    checkErr && !frameStart && !syncClr |=> checkErr)
    else $error("error flag dropped without preset");

  c_tx_frame: cover property (@(posedge clk_sys) disable iff (!rst_n)
    outValid && outReady && sel_r);
  c_rx_good: cover property (@(posedge clk_sys) disable iff (!rst_n)
    frameDone && !tx_r && frameGood && checkMatch);
  c_rx_bad: cover property (@(posedge clk_sys) disable iff (!rst_n)
    frameDone && checkErr);
endmodule

//--- tb/rce_far_sink.sv
`timescale 1ns/1ps
// Far-end sink for the appended check bytes.
// It stalls at random, so the engine must hold each byte until it is taken.
module rce_far_sink (
  input wire logic clk_sys,
  input wire logic rst_n,
  output logic outReady
);
  int seed;
  initial begin
    seed = 32'h6f95_0be3;
    outReady = 1'b0;
  end
  // Bytes are taken in arrival order, so the low half is expected first.
  always @(posedge clk_sys) begin
    #2 outReady = rst_n && ($random(seed) % 2 != 0);
  end
endmodule

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import rce_pkg::*;
  logic clk_sys, rst_n, clkEn, syncClr, frameStart, txMode, inValid, inReady;
  logic outValid, outReady, frameDone, frameGood, checkMatch, checkErr;
  logic [8:0] dataLen;
  logic [7:0] inData, outData;
  logic [15:0] crcValue;
  logic [7:0] fb[$], byteQ[$];
  logic [7:0] statQ[$];
  int err_count, tests_run, seed, cyc, n;
  logic t, b;

  rce_crc16_engine rce_crc16_engine_inst (.clk_sys, .rst_n, .clkEn, .syncClr, .frameStart,
    .txMode, .dataLen, .inValid, .inReady, .inData, .outValid, .outReady, .outData,
    .crcValue, .frameDone, .frameGood, .checkMatch, .checkErr);
  rce_far_sink rce_far_sink_inst (.clk_sys, .rst_n, .outReady);

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Reference register update, one byte and eight conditional shifts.
  function automatic logic [15:0] crcStep(input logic [15:0] c, input logic [7:0] d);
    c = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    return c;
  endfunction

  task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] s);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic cmp16(input string nm, input logic [15:0] e, input logic [15:0] s);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic end_sim();
    $display("Checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic tick();
    @(posedge clk_sys);
    #2;
  endtask

  // Sends the bytes in fb as one frame; receive frames get their check bytes appended.
  task automatic sendFrame(input logic tx, input logic bad);
    logic [15:0] c;
    logic [15:0] h;
    int w;
    c = 16'hFFFF;
    foreach (fb[i]) c = crcStep(c, fb[i]);
    if (tx) begin
      byteQ.push_back(c[7:0]);
      byteQ.push_back(c[15:8]);
    end else begin
      fb.push_back(c[7:0] ^ {7'b0, bad});
      fb.push_back(c[15:8]);
    end
    statQ.push_back({5'b0, tx | !bad, !tx & !bad, !tx & bad});
    frameStart = 1'b1;
    txMode = tx;
    dataLen = 9'(fb.size() - (tx ? 0 : 2));
    tick();
    frameStart = 1'b0;
    cmp16("preset", 16'hFFFF, crcValue);
    cmp8("errClear", 8'h00, {7'b0, checkErr});
    c = 16'hFFFF;
    foreach (fb[i]) begin
      inData = fb[i];
      inValid = 1'b1;
      while (inReady !== 1'b1) tick();
      tick();
      inValid = 1'b0;
      inData = ~fb[i];
      c = crcStep(c, fb[i]);
      for (int k = 0; k < 8; k++) begin
        cmp8("busy", 8'h00, {7'b0, inReady});
        // A low clock enable mid-byte must neither shift nor count a step.
        if (k == 3 && i == 0) begin
          h = crcValue;
          clkEn = 1'b0;
          repeat (3) tick();
          cmp16("frozen", h, crcValue);
          clkEn = 1'b1;
        end
        tick();
      end
      cmp16("crc", c, crcValue);
      cmp8("readyBack", {7'b0, i < fb.size() - 1}, {7'b0, inReady});
    end
    w = 0;
    while ((byteQ.size() != 0 || statQ.size() != 0) && w < 100) begin
      tick();
      w++;
    end
    cmp8("pending", 8'h00, 8'(byteQ.size() + statQ.size()));
  endtask

  // Watches the outputs and matches each result with the oldest note.
  always @(posedge clk_sys) begin
    if (outValid === 1'b1 && outReady === 1'b1) begin
      if (byteQ.size() == 0) cmp8("extraByte", 8'h00, 8'hFF);
      else cmp8("checkByte", byteQ.pop_front(), outData);
    end
    if (frameDone === 1'b1) begin
      if (statQ.size() == 0) cmp8("extraDone", 8'h00, 8'hFF);
      else cmp8("status", statQ.pop_front(), {5'b0, frameGood, checkMatch, checkErr});
    end
  end

  // Cuts a hang short well beyond the length of the planned frames.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end

  initial begin
    seed = 32'h6f95_0be3;
    {clkEn, syncClr, frameStart, txMode, inValid, dataLen, inData} = '0;
    clkEn = 1'b1;
    rst_n = 1'b0;
    repeat (12) @(posedge clk_sys);
    #2 rst_n = 1'b1;
    cmp16("resetCrc", 16'hFFFF, crcValue);
    cmp16("model", 16'hE241, crcStep(crcStep(16'hFFFF, 8'h01), 8'h07));
    fb = '{8'h01, 8'h07};
    sendFrame(1'b1, 1'b0);
    fb = '{8'h01, 8'h07};
    sendFrame(1'b0, 1'b0);
    fb = '{8'h01, 8'h07};
    sendFrame(1'b0, 1'b1);
    repeat (3) tick();
    cmp8("sticky", 8'h01, {7'b0, checkErr});
    syncClr = 1'b1;
    tick();
    syncClr = 1'b0;
    cmp16("clrCrc", 16'hFFFF, crcValue);
    cmp8("clrErr", 8'h00, {7'b0, checkErr});
    for (int f = 0; f < 8; f++) begin
      fb = {};
      n = 1 + ({$random(seed)} % 8);
      repeat (n) fb.push_back(8'($random(seed)));
      t = 1'($random(seed));
      b = !t && 1'($random(seed));
      sendFrame(t, b);
    end
    end_sim();
  end
endmodule
